/* File: rtl/icl_pkg.sv */
// Package for the input current limit register bank: offsets, fields, reset values, types
package icl_pkg;

  // Command codes of the word registers
  localparam logic [7:0]  CMD_EFFECTIVE_INPUT_LIMIT = 8'h22;
  localparam logic [7:0]  CMD_MIN_SYSTEM_VOLTAGE    = 8'h3E;
  localparam logic [7:0]  CMD_HOST_INPUT_LIMIT      = 8'h3F;

  // Field layout of the current limit words
  localparam int          LIMIT_LSB                 = 8;
  localparam int          LIMIT_MSB                 = 14;
  localparam int          LIMIT_RSVD_BIT            = 15;
  localparam int          LIMIT_W                   = 7;

  // Field layout of the minimum system voltage word
  localparam int          MINSYS_LSB                = 8;
  localparam int          MINSYS_MSB                = 13;
  localparam int          MINSYS_W                  = 6;

  // Reset values
  localparam logic [15:0] HOST_INPUT_LIMIT_RESET    = 16'h4000;
  localparam logic [15:0] EFFECTIVE_LIMIT_RESET     = 16'h0000;
  localparam logic [15:0] MIN_SYSTEM_VOLTAGE_RESET  = 16'h0E00;

  // Minimum system voltage legal code range, 1.024 V to 16.128 V in 256 mV steps
  localparam logic [5:0]  MINSYS_CODE_MIN           = 6'h04;
  localparam logic [5:0]  MINSYS_CODE_MAX           = 6'h3F;

  // Current scale: 50 mA per code step and 50 mA offset
  localparam logic [12:0] LIMIT_STEP_MA             = 13'h0032;
  localparam logic [12:0] LIMIT_OFFSET_MA           = 13'h0032;

  // Command-level word access after SMBus framing
  typedef struct packed {
    logic [7:0]  cmd;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } icl_req_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [LIMIT_W-1:0]  host_code;
    logic [LIMIT_W-1:0]  eff_code;
    logic [MINSYS_W-1:0] minsys_code;
    logic [15:0]         rdata;
    logic                rd_valid;
    logic                invalid;
    logic                reduce;
  } icl_state_t;

endpackage : icl_pkg

/* File: rtl/icl_regs.sv */
// Input current limit register bank with effective limit readback and minimum system voltage
`timescale 1ns/1ns
module icl_regs
  import icl_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                arst_n_i,
  input  wire icl_req_t            req_i,
  output logic [15:0]              rdata_o,
  output logic                     rd_valid_o,
  output logic                     invalid_write_o,
  input  wire logic                adapter_present_i,
  input  wire logic                optimizer_active_i,
  input  wire logic [LIMIT_W-1:0]  optimizer_code_i,
  input  wire logic                input_over_current_i,
  input  wire logic                input_under_voltage_i,
  output logic [LIMIT_W-1:0]       host_limit_code_o,
  output logic [LIMIT_W-1:0]       effective_limit_code_o,
  output logic [12:0]              effective_limit_ma_o,
  output logic [MINSYS_W-1:0]      min_system_code_o,
  output logic                     charge_reduce_o
);

  icl_state_t state;
  icl_state_t next_state;

  localparam icl_state_t STATE_RESET = '{
    host_code:   HOST_INPUT_LIMIT_RESET[LIMIT_MSB:LIMIT_LSB],
    eff_code:    EFFECTIVE_LIMIT_RESET[LIMIT_MSB:LIMIT_LSB],
    minsys_code: MIN_SYSTEM_VOLTAGE_RESET[MINSYS_MSB:MINSYS_LSB],
    rdata:       16'h0000,
    rd_valid:    1'b0,
    invalid:     1'b0,
    reduce:      1'b0
  };

  // Next state: word writes, reads, adapter removal, optimizer and load priority
  always_comb begin
    logic              host_wr;
    logic              minsys_wr;
    logic [MINSYS_W-1:0] ms;
    next_state = state;
    host_wr    = req_i.wr && (req_i.cmd == CMD_HOST_INPUT_LIMIT);
    minsys_wr  = req_i.wr && (req_i.cmd == CMD_MIN_SYSTEM_VOLTAGE);
    ms         = req_i.wdata[MINSYS_MSB:MINSYS_LSB];
    next_state.invalid  = 1'b0;
    next_state.rd_valid = 1'b0;

    // Host limit word write; reserved low byte dropped
    if (host_wr) begin
      if (req_i.wdata[LIMIT_RSVD_BIT]) begin
        next_state.invalid = 1'b1;
      end else begin
        next_state.host_code = req_i.wdata[LIMIT_MSB:LIMIT_LSB];
      end
    end

    // Minimum system voltage write, out of range or reserved bits refused
    if (minsys_wr) begin
      if (req_i.wdata[15:14] != 2'b00) begin
        next_state.invalid = 1'b1;
      end else if (ms >= MINSYS_CODE_MIN && ms <= MINSYS_CODE_MAX) begin
        next_state.minsys_code = ms;
      end
    end

    // Removal of the adapter restores the default, overriding any write
    if (!adapter_present_i) begin
      next_state.host_code = HOST_INPUT_LIMIT_RESET[LIMIT_MSB:LIMIT_LSB];
    end

    // Limit in force: optimizer result or host code
    if (optimizer_active_i) begin
      next_state.eff_code = optimizer_code_i;
    end else begin
      next_state.eff_code = state.host_code;
    end

    // Word read; unmapped codes and reserved bits read zero
    if (req_i.rd) begin
      next_state.rd_valid = 1'b1;
      unique case (req_i.cmd)
        CMD_HOST_INPUT_LIMIT:
          next_state.rdata = {1'b0, state.host_code, 8'h00};
        CMD_EFFECTIVE_INPUT_LIMIT:
          next_state.rdata = {1'b0, state.eff_code, 8'h00};
        CMD_MIN_SYSTEM_VOLTAGE:
          next_state.rdata = {2'b00, state.minsys_code, 8'h00};
        default:
          next_state.rdata = 16'h0000;
      endcase
    end

    // System load takes priority over charging
    next_state.reduce = input_over_current_i | input_under_voltage_i;
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state
  assign rdata_o                = state.rdata;
  assign rd_valid_o             = state.rd_valid;
  assign invalid_write_o        = state.invalid;
  assign host_limit_code_o      = state.host_code;
  assign effective_limit_code_o = state.eff_code;
  assign min_system_code_o      = state.minsys_code;
  assign charge_reduce_o        = state.reduce;

  // Limit in milliamps with the fixed offset, code zero gives 50 mA
  assign effective_limit_ma_o   = 13'({6'h00, state.eff_code} * LIMIT_STEP_MA)
                                  + LIMIT_OFFSET_MA;

endmodule : icl_regs

/* File: verification/icl_host.sv */
// Host controller model issuing decoded word commands
`timescale 1ns/1ns
module icl_host
  import icl_pkg::*;
(
  input  wire logic ref_clk_i,
  output icl_req_t  req_o
);
  initial req_o = '0;
  // One whole 16-bit word command, held for one taking edge
  task automatic word(input logic [7:0] cmd, input logic wr, input logic [15:0] wd);
    @(posedge ref_clk_i) #1;
    req_o = '{cmd: cmd, wr: wr, rd: !wr, wdata: wd};
    @(posedge ref_clk_i) #1;
    req_o = '0;
  endtask : word
endmodule : icl_host

/* File: verification/icl_regs_sva.sv */
// Port assertions for the input current limit register bank
`timescale 1ns/1ns
module icl_regs_sva
  import icl_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       arst_n_i,
  input wire icl_req_t   req_i,
  input wire logic [15:0] rdata_o,
  input wire logic       rd_valid_o,
  input wire logic       invalid_write_o,
  input wire logic       adapter_present_i,
  input wire logic       optimizer_active_i,
  input wire logic [6:0] optimizer_code_i,
  input wire logic [6:0] host_limit_code_o,
  input wire logic [6:0] effective_limit_code_o,
  input wire logic [12:0] effective_limit_ma_o
);
  logic wr3f;
  // Write aimed at the host limit word
  assign wr3f = req_i.wr && req_i.cmd == CMD_HOST_INPUT_LIMIT && adapter_present_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  host_wr_a: assert property (wr3f && !req_i.wdata[15]
    |=> host_limit_code_o == $past(req_i.wdata[14:8])) else $error("host code not taken");
  rsvd_wr_a: assert property (wr3f && req_i.wdata[15]
    |=> invalid_write_o && $stable(host_limit_code_o)) else $error("bad write taken");
  low_zero_a: assert property (rd_valid_o |-> rdata_o[7:0] == 8'h00) else $error("low byte");
  ma_calc_a: assert property (effective_limit_ma_o == {6'h00, effective_limit_code_o} * 13'h0032
    + 13'h0032) else $error("mA wrong");
  unplug_a: assert property (!adapter_present_i |=> host_limit_code_o == 7'h40) else $error("unplug");
  eff_host_a: assert property (!optimizer_active_i
    |=> effective_limit_code_o == $past(host_limit_code_o)) else $error("eff not host");
  eff_opt_a: assert property (optimizer_active_i
    |=> effective_limit_code_o == $past(optimizer_code_i)) else $error("eff not optimizer");
  eff_read_a: assert property (req_i.rd && req_i.cmd == CMD_EFFECTIVE_INPUT_LIMIT |=> rd_valid_o
    && rdata_o == {1'b0, $past(effective_limit_code_o), 8'h00}) else $error("eff read");
  cover property (wr3f && req_i.wdata[15]);
  cover property (!adapter_present_i);
  cover property (optimizer_active_i);
endmodule : icl_regs_sva

/* File: verification/icl_regs_test.sv */
// Self-checking bench for the input current limit register bank
`timescale 1ns/1ns
module icl_regs_test;
  import icl_pkg::*;
  logic clk = 0, rst_n = 1, adp = 1, opt = 0, oc = 0, uv = 0, rdv, inv, red;
  logic [6:0] opc = 7'h05, hc, ec;
  logic [15:0] rdata;
  logic [12:0] ma;
  logic [5:0] ms;
  icl_req_t req;
  int error_cnt = 0, n_tests = 0;
  // Free-running 125 MHz clock
  always #4 clk = ~clk;
  icl_host i_host (.ref_clk_i(clk), .req_o(req));
  icl_regs i_dut (.ref_clk_i(clk), .arst_n_i(rst_n), .req_i(req), .rdata_o(rdata),
    .rd_valid_o(rdv), .invalid_write_o(inv), .adapter_present_i(adp),
    .optimizer_active_i(opt), .optimizer_code_i(opc), .input_over_current_i(oc),
    .input_under_voltage_i(uv), .host_limit_code_o(hc), .effective_limit_code_o(ec),
    .effective_limit_ma_o(ma), .min_system_code_o(ms), .charge_reduce_o(red));
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Read one word and judge pulse and data
  task rd(input logic [7:0] cmd, input logic [15:0] exp);
    i_host.word(cmd, 1'b0, 16'h0000);
    check({15'h0000, rdv}, 16'h0001);
    check(rdata, exp);
  endtask : rd
  task step;
    @(posedge clk) #1;
  endtask : step
  // Reset asserted off the edge so the flops see a real falling edge, held four cycles
  task t_reset;
    rst_n = 0;
    repeat (4) @(posedge clk);
    #1;
    check({3'h0, ma}, 16'h0032);
    check({9'h000, ec}, 16'h0000);
    rst_n = 1;
    rd(8'h3F, 16'h4000);
  endtask : t_reset
  task t_write;
    i_host.word(8'h3F, 1'b1, 16'h12FF);
    rd(8'h3F, 16'h1200);
    rd(8'h22, 16'h1200);
    i_host.word(8'h3F, 1'b1, 16'h0000);
    step;
    check({3'h0, ma}, 16'h0032);
  endtask : t_write
  task t_bad;
    i_host.word(8'h3F, 1'b1, 16'hC000);
    check({15'h0000, inv}, 16'h0001);
    rd(8'h3F, 16'h0000);
  endtask : t_bad
  task t_unplug;
    adp = 0;
    step;
    adp = 1;
    rd(8'h3F, 16'h4000);
  endtask : t_unplug
  task t_opt;
    opt = 1;
    step;
    rd(8'h22, 16'h0500);
    opt = 0;
  endtask : t_opt
  task t_misc;
    i_host.word(8'h3E, 1'b1, 16'h3F00);
    check({10'h000, ms}, 16'h003F);
    uv = 1;
    step;
    step;
    check({15'h0000, red}, 16'h0001);
    uv = 0;
  endtask : t_misc
  // Host setup without a battery switch: foreign commands leave the limit alone
  task t_idle;
    i_host.word(8'h32, 1'b1, 16'h8000);
    i_host.word(8'h12, 1'b1, 16'h0000);
    i_host.word(8'h30, 1'b1, 16'h0000);
    rd(8'h15, 16'h0000);
    i_host.word(8'h14, 1'b1, 16'h0000);
    i_host.word(8'h31, 1'b1, 16'h0080);
    check({9'h000, hc}, 16'h0040);
    i_host.word(8'h32, 1'b1, 16'h0000);
    i_host.word(8'h3F, 1'b1, 16'h0600);
    rd(8'h3F, 16'h0600);
  endtask : t_idle
  task close_out;
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Main sequence after a four-cycle reset
  initial begin
    #1;
    t_reset;
    t_write;
    t_bad;
    t_unplug;
    t_opt;
    t_misc;
    t_idle;
    close_out;
  end
endmodule : icl_regs_test
bind icl_regs icl_regs_sva u_sva (.*);
